/* File: src/lcr_pkg.sv */
package lcr_pkg;
    localparam logic [11:0] LINK_CONTROL_OFFSET = 12'h050;
    localparam logic [15:0] LINK_CONTROL_RESET  = 16'h0000;
    localparam int          PSE_LSB   = 0;
    localparam int          RSVD_BIT  = 2;
    localparam int          RCB_BIT   = 3;
    localparam int          OFF_BIT   = 4;
    localparam int          RET_BIT   = 5;
    localparam int          CLK_BIT   = 6;
    localparam logic [1:0]  PSE_OFF   = 2'h0;
    localparam logic [1:0]  PSE_L0S   = 2'h1;
    localparam logic [1:0]  PSE_L1    = 2'h2;
    localparam logic [1:0]  PSE_BOTH  = 2'h3;
    localparam int          CLK_HZ    = 20000000;
    localparam int          UP_DELAY_US = 1000;
    localparam int          UP_DELAY_CYC = CLK_HZ / 1000000 * UP_DELAY_US;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [11:0] addr;
        logic [15:0] wdata;
    } lcr_req_s;

    typedef struct packed {
        logic [1:0] pse;
        logic       link_off;
        logic       shared_refclk;
    } lcr_ctl_s;
endpackage

/* File: src/lcr_link_control.sv */
// Contract
// - power_state_entry_enable resets to 0; 1 = L0s, 2 = L1, 3 = both.
// - an EEPROM-loaded value may replace the zero default of power_state_entry_enable.
// - L0s enable governs only transmitter L0s entry; receiver L0s is always supported.
// - read_completion_boundary is read-only and reads zero.
// - link_off disables the link on a downstream port and does nothing upstream.
// - writing one to link_retrain_trigger sends the training machine to Recovery.
// - link_retrain_trigger always reads back zero.
// - one write may set retrain and change other fields, both taking effect.
// - changes during Recovery/Configuration wait for the next retrain, else apply now; the code also applies them once Recovery/Configuration ends.
// - upstream with unlock clear, retrain has no effect and reads zero.
// - upstream with unlock set, retrain starts 1 ms after the write.
// - upstream, the training flag sets only after the 1 ms delay.
// - shared_refclk_config is read-write, resets to zero, marks a shared refclk.
module lcr_link_control
    import lcr_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b0,
    parameter int DELAY_CYC   = UP_DELAY_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire lcr_req_s    cfg_req,
    output logic [15:0]      cfg_rdata,
    output logic             cfg_ack,
    input  wire logic        eeprom_load,
    input  wire logic [1:0]  eeprom_pse,
    input  wire logic        upstream_register_unlock,
    input  wire logic        ltssm_in_rec_cfg,
    output lcr_ctl_s         ctl_out,
    output logic             tx_l0s_enable,
    output logic             rx_l0s_enable,
    output logic             l1_enable,
    output logic             retrain_pulse,
    output logic             link_training_flag
);
    lcr_ctl_s    reg_q, reg_d;
    lcr_ctl_s    act_q, act_d;
    logic        pend_q, pend_d;
    logic [31:0] cnt_q, cnt_d;
    logic        dly_q, dly_d;
    logic        ret_q, ret_d;
    logic        flag_q, flag_d;
    logic        ack_q, ack_d;
    logic [15:0] rd_q, rd_d;
    logic        hit, wr_ret, ret_fire;

    function automatic logic [15:0] pack_reg(input lcr_ctl_s c);
        logic [15:0] v;
        v = 16'h0000;
        v[PSE_LSB +: 2] = c.pse;
        v[OFF_BIT]      = c.link_off;
        v[CLK_BIT]      = c.shared_refclk;
        return v; // bits 2, 3, 5 stay zero
    endfunction

    always_comb begin
        hit    = cfg_req.valid && (cfg_req.addr == LINK_CONTROL_OFFSET);
        wr_ret = hit && cfg_req.write && cfg_req.wdata[RET_BIT]
                 && (!IS_UPSTREAM || upstream_register_unlock);
        reg_d  = reg_q;
        if (hit && cfg_req.write) begin
            reg_d.pse           = cfg_req.wdata[PSE_LSB +: 2];
            reg_d.link_off      = cfg_req.wdata[OFF_BIT];
            reg_d.shared_refclk = cfg_req.wdata[CLK_BIT];
        end else if (eeprom_load) begin
            reg_d.pse = eeprom_pse;
        end
        ack_d = hit;
        rd_d  = (hit && !cfg_req.write) ? pack_reg(reg_q) : 16'h0000;
    end

    // upstream delay counter
    always_comb begin
        cnt_d = cnt_q;
        dly_d = dly_q;
        ret_fire = 1'b0;
        if (wr_ret && IS_UPSTREAM) begin
            dly_d = 1'b1;
            cnt_d = 32'h00000000;
        end else if (dly_q) begin
            if (cnt_q == 32'(DELAY_CYC - 1)) begin
                dly_d = 1'b0;
                ret_fire = 1'b1;
            end else begin
                cnt_d = cnt_q + 32'h00000001;
            end
        end
        if (wr_ret && !IS_UPSTREAM) begin
            ret_fire = 1'b1;
        end
        ret_d  = ret_fire;
        flag_d = ret_fire ? 1'b1 : (flag_q && ltssm_in_rec_cfg);
    end

    // applied controls; held while training unless a retrain pulse is issued
    always_comb begin
        act_d  = act_q;
        pend_d = pend_q;
        if (ltssm_in_rec_cfg && !ret_q) begin
            pend_d = pend_q || (reg_d != act_q);
        end else begin
            act_d  = reg_d;
            pend_d = 1'b0;
        end
        if (IS_UPSTREAM) begin
            act_d.link_off = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_q  <= LINK_CONTROL_RESET[6:0] == 7'h00 ? '0 : '0;
            act_q  <= '0;
            pend_q <= 1'b0;
            cnt_q  <= 32'h00000000;
            dly_q  <= 1'b0;
            ret_q  <= 1'b0;
            flag_q <= 1'b0;
            ack_q  <= 1'b0;
            rd_q   <= 16'h0000;
        end else begin
            reg_q  <= reg_d;
            act_q  <= act_d;
            pend_q <= pend_d;
            cnt_q  <= cnt_d;
            dly_q  <= dly_d;
            ret_q  <= ret_d;
            flag_q <= flag_d;
            ack_q  <= ack_d;
            rd_q   <= rd_d;
        end
    end

    assign cfg_rdata          = rd_q;
    assign cfg_ack            = ack_q;
    assign ctl_out            = act_q;
    assign tx_l0s_enable      = act_q.pse[0];
    assign rx_l0s_enable      = 1'b1;
    assign l1_enable          = act_q.pse[1];
    assign retrain_pulse      = ret_q;
    assign link_training_flag = flag_q;

    rd_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        (cfg_rdata[RET_BIT] == 1'b0) && (cfg_rdata[RCB_BIT] == 1'b0)
        && (cfg_rdata[RSVD_BIT] == 1'b0)) else $error("fixed zero bits read nonzero");
    pse_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        hit && !cfg_req.write |=> cfg_rdata[1:0] == $past(reg_q.pse))
        else $error("entry field readback wrong");
    ret_down_a: assert property (@(posedge ref_clk) disable iff (rst)
        !IS_UPSTREAM && wr_ret |=> retrain_pulse) else $error("retrain missing");
    up_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
        IS_UPSTREAM && hit && cfg_req.write && !upstream_register_unlock && !dly_q
        |=> !retrain_pulse) else $error("locked retrain fired");
    up_early_a: assert property (@(posedge ref_clk) disable iff (rst)
        IS_UPSTREAM && wr_ret |=> !retrain_pulse && !$rose(link_training_flag))
        else $error("upstream retrain too early");
    flag_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        retrain_pulse |-> link_training_flag) else $error("flag not set at retrain");
    both_take_a: assert property (@(posedge ref_clk) disable iff (rst)
        hit && cfg_req.write |=> reg_q.shared_refclk == $past(cfg_req.wdata[CLK_BIT]))
        else $error("field write lost");
    up_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        IS_UPSTREAM |-> !ctl_out.link_off) else $error("link off on upstream");
    rx_l0s_a: assert property (@(posedge ref_clk) disable iff (rst)
        rx_l0s_enable && (tx_l0s_enable == ctl_out.pse[0])) else $error("l0s split wrong");

    // register access checks
    ack_hit_a: assert property (@(posedge ref_clk) disable iff (rst)
        hit
        |=> cfg_ack)
        else $error("access not acknowledged");

    ack_miss_a: assert property (@(posedge ref_clk) disable iff (rst)
        !hit
        |=> !cfg_ack)
        else $error("stray acknowledge");

    rd_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        !cfg_ack
        |-> cfg_rdata == 16'h0000)
        else $error("read data outside ack");

    rd_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_ack
        |-> cfg_rdata[15:7] == 9'h000)
        else $error("upper bits read nonzero");

    rd_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        hit && cfg_req.write
        |=> cfg_rdata == 16'h0000)
        else $error("write returned data");

    pse_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        hit && cfg_req.write
        |=> reg_q.pse == $past(cfg_req.wdata[PSE_LSB +: 2]))
        else $error("entry field write lost");

    off_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        hit && cfg_req.write
        |=> reg_q.link_off == $past(cfg_req.wdata[OFF_BIT]))
        else $error("link off write lost");

    eeprom_take_a: assert property (@(posedge ref_clk) disable iff (rst)
        eeprom_load && !(hit && cfg_req.write)
        |=> reg_q.pse == $past(eeprom_pse))
        else $error("loaded entry value lost");

    reg_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !(hit && cfg_req.write) && !eeprom_load
        |=> $stable(reg_q))
        else $error("register changed without write");

    l1_map_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1
        |-> l1_enable == ctl_out.pse[1])
        else $error("l1 enable mismatch");

    rd_clk_a: assert property (@(posedge ref_clk) disable iff (rst)
        hit && !cfg_req.write
        |=> cfg_rdata[CLK_BIT] == $past(reg_q.shared_refclk))
        else $error("refclk bit readback wrong");

    rd_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        hit && !cfg_req.write
        |=> cfg_rdata[OFF_BIT] == $past(reg_q.link_off))
        else $error("link off readback wrong");

    rst_clear_a: assert property (@(posedge ref_clk)
        $past(rst)
        |-> (ctl_out == '0) && !retrain_pulse && !link_training_flag && !cfg_ack)
        else $error("state not cleared by reset");

    // retrain timing checks
    up_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
        IS_UPSTREAM && dly_q && (cnt_q == 32'(DELAY_CYC - 1)) && !wr_ret
        |=> retrain_pulse)
        else $error("delayed retrain missing");

    dly_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        IS_UPSTREAM && !(dly_q && (cnt_q == 32'(DELAY_CYC - 1)) && !wr_ret)
        |=> !retrain_pulse)
        else $error("upstream retrain off schedule");

    cnt_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
        dly_q
        |-> cnt_q < 32'(DELAY_CYC))
        else $error("delay count overrun");

    cnt_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        IS_UPSTREAM && wr_ret
        |=> dly_q && (cnt_q == 32'h00000000))
        else $error("delay not restarted");

    dly_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        IS_UPSTREAM && retrain_pulse
        |-> !dly_q)
        else $error("delay still running at retrain");

    down_nodly_a: assert property (@(posedge ref_clk) disable iff (rst)
        !IS_UPSTREAM
        |-> !dly_q)
        else $error("downstream delay active");

    ret_once_a: assert property (@(posedge ref_clk) disable iff (rst)
        IS_UPSTREAM && retrain_pulse
        |=> !retrain_pulse)
        else $error("upstream retrain repeated");

    wr_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
        IS_UPSTREAM && !upstream_register_unlock
        |-> !wr_ret)
        else $error("locked retrain accepted");

    flag_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(link_training_flag)
        |-> retrain_pulse)
        else $error("training flag set without retrain");

    flag_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
        link_training_flag && !ltssm_in_rec_cfg && !ret_fire
        |=> !link_training_flag)
        else $error("training flag held too long");

    // applied control checks
    act_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        ltssm_in_rec_cfg && !retrain_pulse
        |=> $stable(ctl_out))
        else $error("controls changed during training");

    act_apply_a: assert property (@(posedge ref_clk) disable iff (rst)
        !ltssm_in_rec_cfg || retrain_pulse
        |=> (ctl_out.pse == reg_q.pse) && (ctl_out.shared_refclk == reg_q.shared_refclk))
        else $error("controls not applied");

    pend_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        !ltssm_in_rec_cfg
        |=> !pend_q)
        else $error("pending change left over");

    down_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        !IS_UPSTREAM && (!ltssm_in_rec_cfg || retrain_pulse)
        |=> ctl_out.link_off == reg_q.link_off)
        else $error("downstream link off not applied");
endmodule

/* File: sim/lcr_ltssm_model.sv */
module lcr_ltssm_model
    import lcr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic retrain_pulse,
    output logic      in_rec_cfg
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_q;
    // recovery and configuration span a few cycles after each retrain
    always_ff @(posedge ref_clk) begin
        if (rst) cnt_q <= 3'h0;
        else if (retrain_pulse) cnt_q <= 3'h5;
        else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    end
    assign in_rec_cfg = (cnt_q != 3'h0);
endmodule

/* File: sim/pcie_link_control_register_tb_top.sv */
module pcie_link_control_register_tb_top
    import lcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DLY = 8;
    logic ref_clk = 1'b0, rst = 1'b1, ack, eld = 1'b0, unl = 1'b0, rec, tx0, rx0, l1, pls, flg;
    logic [1:0] epse = 2'h0;
    logic [15:0] rd;
    lcr_req_s req = '0;
    lcr_ctl_s ctl;
    int n_errors = 0, total_checks = 0, k;
    always #25 ref_clk = ~ref_clk;
    lcr_link_control #(.IS_UPSTREAM(1'b1), .DELAY_CYC(DLY)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .cfg_req(req), .cfg_rdata(rd), .cfg_ack(ack), .eeprom_load(eld), .eeprom_pse(epse),
        .upstream_register_unlock(unl), .ltssm_in_rec_cfg(rec), .ctl_out(ctl),
        .tx_l0s_enable(tx0), .rx_l0s_enable(rx0), .l1_enable(l1), .retrain_pulse(pls),
        .link_training_flag(flg));
    lcr_ltssm_model i_ltssm (.ref_clk(ref_clk), .rst(rst), .retrain_pulse(pls), .in_rec_cfg(rec));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task acc(input logic wr, input logic [15:0] wd, output logic [15:0] q);
        @(posedge ref_clk);
        #1 req = '{1'b1, wr, LINK_CONTROL_OFFSET, wd};
        @(posedge ref_clk);
        #1 req.valid = 1'b0;
        chk({15'h0, ack}, 16'h1);
        q = rd;
    endtask
    task t_reset;
        logic [15:0] q;
        acc(1'b0, 16'h0, q);
        chk(q, LINK_CONTROL_RESET);
        chk({15'h0, rx0}, 16'h1);
        $display("test reset done");
    endtask
    task t_fields;
        logic [15:0] q;
        for (int v = 0; v < 4; v++) begin
            acc(1'b1, 16'(v), q);
            acc(1'b0, 16'h0, q);
            chk({14'h0, l1, tx0}, 16'(v));
        end
        acc(1'b1, 16'h007F, q);
        acc(1'b0, 16'h0, q);
        chk(q, 16'h0053);
        chk({12'h0, ctl}, 16'h000D);
        chk({15'h0, pls | flg}, 16'h0);
        $display("test fields done");
    endtask
    task t_eeprom;
        logic [15:0] q;
        @(posedge ref_clk);
        #1 {eld, epse} = 3'h6;
        @(posedge ref_clk);
        #1 eld = 1'b0;
        acc(1'b0, 16'h0, q);
        chk(q, 16'h0052);
        $display("test eeprom done");
    endtask
    task t_retrain;
        logic [15:0] q;
        unl = 1'b1;
        acc(1'b1, 16'h0021, q);
        k = 0;
        while (pls !== 1'b1 && k < 20) begin
            chk({15'h0, flg}, 16'h0);
            @(posedge ref_clk);
            #1 k++;
        end
        chk({15'h0, k >= DLY - 1 && k <= DLY + 1}, 16'h1);
        chk({15'h0, flg}, 16'h1);
        acc(1'b0, 16'h0, q);
        chk(q, 16'h0001);
        chk({14'h0, ctl.pse}, 16'h1);
        $display("test retrain done");
    endtask
    task report_and_stop;
        $display("errors=%0d checks=%0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #20us n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        t_reset();
        t_fields();
        t_eeprom();
        t_retrain();
        report_and_stop();
    end
endmodule
